// file: rtl/csrb_pkg.sv
/*
 Package for the conditioner system register bank: register indices,
 field positions, reset values and the request and reply carriers.
 Assumes a frame engine on the same clock that decodes diagnostic frames.
*/
package csrb_pkg;

    localparam logic [7:0] ADDR_AMP_CTRL = 8'hB0;
    localparam logic [7:0] ADDR_AMP_GAIN = 8'hB1;
    localparam logic [7:0] ADDR_OFS_FIRST = 8'hB2;
    localparam logic [7:0] ADDR_OFS_SECOND = 8'hB3;
    localparam logic [7:0] ADDR_OFS_THIRD = 8'hB4;
    localparam logic [7:0] ADDR_EXT_GAIN = 8'hB5;
    localparam logic [7:0] ADDR_EXT_SINK = 8'hB6;
    localparam logic [7:0] ADDR_NVM_STATUS = 8'hBB;
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'hBC;
    localparam logic [7:0] ADDR_FAULT_EN = 8'hBD;
    localparam logic [7:0] ADDR_FAULT_REC = 8'hBE;
    localparam logic [7:0] ADDR_SI_REV = 8'hD0;

    localparam int AMP_CTRL_W = 2;
    localparam int AMP_GAIN_W = 5;
    localparam int DAC_W = 7;
    localparam int HI_CODE_LSB = 8;
    localparam int EXT_GAIN_W = 10;
    localparam int SINK_W = 3;
    localparam int SENS_FIRST_LSB = 7;
    localparam int SENS_SECOND_LSB = 5;
    localparam int REF_FIRST_LSB = 2;
    localparam int REF_SECOND_LSB = 0;
    localparam int FIRST_GAIN_W = 3;
    localparam int SECOND_GAIN_W = 2;
    localparam int FLOAT_CUR_BIT = 1;
    localparam int REVERSE_BIT = 0;
    localparam int REV_W = 16;

    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        logic [7:0] addr;
        logic [31:0] data;
    } csrb_req_type;

    typedef struct packed {
        logic valid;
        logic ok;
        logic [31:0] data;
    } csrb_rsp_type;

    typedef struct packed {
        logic busy;
        logic progDone;
        logic enableTimeout;
        logic progTimeout;
        logic readTimeout;
        logic eccFail;
        logic eccUsed;
        logic progStatus;
    } csrb_nvm_type;

endpackage

// file: rtl/csrb_bank.sv
/*
 Conditioner system register bank: the register map reached by
 diagnostic read and write frames, with codes driven to the analog side.
 Assumes a frame engine, fault handler and memory engine on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module csrb_bank #(
    // Arbitrary revision value.
    parameter logic [15:0] SILICON_REV = 16'h0001
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire csrb_pkg::csrb_req_type req,
    output csrb_pkg::csrb_rsp_type rsp,
    input wire logic [31:0] faultEvent,
    input wire logic [31:0] faultClear,
    input wire csrb_pkg::csrb_nvm_type nvmState,
    output logic floatCurrentHigh,
    output logic reverseInputs,
    output logic [4:0] ampGain,
    output logic [6:0] firstOffsetDacCode,
    output logic [6:0] secondOffsetDacCode,
    output logic [6:0] thirdOffsetDacCode,
    output logic [6:0] positiveOffsetDacCode,
    output logic [6:0] stageThreeDacCode,
    output logic [2:0] sensorFirstGain,
    output logic [1:0] sensorSecondGain,
    output logic [2:0] referenceFirstGain,
    output logic [1:0] referenceSecondGain,
    output logic [2:0] extTempSinkCurrent,
    output logic [31:0] faultDetectEnable,
    output logic [31:0] faultRecordEnable
);
    import csrb_pkg::*;

    logic [31:0] faultFlags;
    logic [7:0] nvmStatus;
    logic [31:0] readData;
    logic readHit;
    logic writeHit;
    logic wrStrobe;
    logic [31:0] next_faultFlags;
    logic rdStrobe;
    logic [31:0] enabledEvents;
    csrb_nvm_type statusSeen;

    function automatic logic isWide(input logic [7:0] a);
        return (a == ADDR_FAULT_FLAGS) || (a == ADDR_FAULT_EN) ||
               (a == ADDR_FAULT_REC);
    endfunction

    function automatic logic [6:0] dacField(input logic [31:0] d,
                                            input int lsb);
        return d[lsb +: DAC_W];
    endfunction

    // Writable addresses; status words ignore writes.
    assign writeHit = (req.addr == ADDR_AMP_CTRL) ||
                      (req.addr == ADDR_AMP_GAIN) ||
                      (req.addr == ADDR_OFS_FIRST) ||
                      (req.addr == ADDR_OFS_SECOND) ||
                      (req.addr == ADDR_OFS_THIRD) ||
                      (req.addr == ADDR_EXT_GAIN) ||
                      (req.addr == ADDR_EXT_SINK) ||
                      (req.addr == ADDR_FAULT_EN) ||
                      (req.addr == ADDR_FAULT_REC);
    assign readHit = writeHit || (req.addr == ADDR_NVM_STATUS) ||
                     (req.addr == ADDR_FAULT_FLAGS) ||
                     (req.addr == ADDR_SI_REV);
    // Command width must suit the register width.
    assign wrStrobe = req.valid && req.write && writeHit &&
                      (req.wide == isWide(req.addr));
    assign rdStrobe = req.valid && !req.write;

    // Status byte mapped bit for bit.
    assign nvmStatus = {nvmState.busy, nvmState.progDone,
                        nvmState.enableTimeout, nvmState.progTimeout,
                        nvmState.readTimeout, nvmState.eccFail,
                        nvmState.eccUsed, nvmState.progStatus};
    assign statusSeen = rsp.data[$bits(csrb_nvm_type)-1:0];

    // Enabled events set flags; a set wins over a clear.
    assign enabledEvents = faultEvent & faultDetectEnable;
    assign next_faultFlags = (faultFlags & ~faultClear) | enabledEvents;

    // Read mux, unassigned bits zero.
    always_comb
    begin
        readData = RESET_ZERO;
        unique case (req.addr)
            ADDR_AMP_CTRL: readData[AMP_CTRL_W-1:0] =
                {floatCurrentHigh, reverseInputs};
            ADDR_AMP_GAIN: readData[AMP_GAIN_W-1:0] = ampGain;
            ADDR_OFS_FIRST: readData[14:0] =
                {secondOffsetDacCode, 1'b0, firstOffsetDacCode};
            ADDR_OFS_SECOND: readData[14:0] =
                {positiveOffsetDacCode, 1'b0, thirdOffsetDacCode};
            ADDR_OFS_THIRD: readData[DAC_W-1:0] = stageThreeDacCode;
            ADDR_EXT_GAIN: readData[EXT_GAIN_W-1:0] =
                {sensorFirstGain, sensorSecondGain,
                 referenceFirstGain, referenceSecondGain};
            ADDR_EXT_SINK: readData[SINK_W-1:0] = extTempSinkCurrent;
            ADDR_NVM_STATUS: readData[7:0] = nvmStatus;
            ADDR_FAULT_FLAGS: readData = faultFlags;
            ADDR_FAULT_EN: readData = faultDetectEnable;
            ADDR_FAULT_REC: readData = faultRecordEnable;
            ADDR_SI_REV: readData[REV_W-1:0] = SILICON_REV;
            default: readData = RESET_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            faultFlags <= RESET_ZERO;
        end
        else
        begin
            faultFlags <= next_faultFlags;
        end
    end

    // Frame answer one cycle after the request.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.valid <= req.valid;
            rsp.ok <= req.valid && readHit && (req.wide == isWide(req.addr))
                      && !(req.write && !writeHit);
            rsp.data <= (req.valid && !req.write) ? readData : RESET_ZERO;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            floatCurrentHigh <= 1'b0;
            reverseInputs <= 1'b0;
            ampGain <= '0;
            firstOffsetDacCode <= '0;
            secondOffsetDacCode <= '0;
            thirdOffsetDacCode <= '0;
            positiveOffsetDacCode <= '0;
            stageThreeDacCode <= '0;
            sensorFirstGain <= '0;
            sensorSecondGain <= '0;
            referenceFirstGain <= '0;
            referenceSecondGain <= '0;
            extTempSinkCurrent <= '0;
            faultDetectEnable <= RESET_ZERO;
            faultRecordEnable <= RESET_ZERO;
        end
        else if (wrStrobe)
        begin
            unique case (req.addr)
                ADDR_AMP_CTRL:
                begin
                    floatCurrentHigh <= req.data[FLOAT_CUR_BIT];
                    reverseInputs <= req.data[REVERSE_BIT];
                end
                ADDR_AMP_GAIN: ampGain <= req.data[AMP_GAIN_W-1:0];
                ADDR_OFS_FIRST:
                begin
                    secondOffsetDacCode <= dacField(req.data, HI_CODE_LSB);
                    firstOffsetDacCode <= dacField(req.data, 0);
                end
                ADDR_OFS_SECOND:
                begin
                    positiveOffsetDacCode <= dacField(req.data, HI_CODE_LSB);
                    thirdOffsetDacCode <= dacField(req.data, 0);
                end
                ADDR_OFS_THIRD: stageThreeDacCode <= dacField(req.data, 0);
                ADDR_EXT_GAIN:
                begin
                    sensorFirstGain <=
                        req.data[SENS_FIRST_LSB +: FIRST_GAIN_W];
                    sensorSecondGain <=
                        req.data[SENS_SECOND_LSB +: SECOND_GAIN_W];
                    referenceFirstGain <=
                        req.data[REF_FIRST_LSB +: FIRST_GAIN_W];
                    referenceSecondGain <=
                        req.data[REF_SECOND_LSB +: SECOND_GAIN_W];
                end
                ADDR_EXT_SINK: extTempSinkCurrent <= req.data[SINK_W-1:0];
                ADDR_FAULT_EN: faultDetectEnable <= req.data;
                ADDR_FAULT_REC: faultRecordEnable <= req.data;
                default: ;
            endcase
        end
    end

    a_fault_set_wins: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (faultEvent[0] && faultDetectEnable[0]) |=> faultFlags[0])
        else $error("Enabled fault did not set its flag.");
    a_fault_gated: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!faultFlags[0] && !faultDetectEnable[0]) |=> !faultFlags[0])
        else $error("Disabled fault set its flag.");
    a_all_enabled_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (enabledEvents != RESET_ZERO) |=>
        (faultFlags & $past(enabledEvents)) == $past(enabledEvents))
        else $error("Enabled faults did not all set their flags.");
    a_flags_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_FAULT_FLAGS) |=>
        rsp.data == $past(faultFlags))
        else $error("Fault word read wrong.");
    a_enable_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_FAULT_EN) |=>
        faultDetectEnable == $past(req.data))
        else $error("Fault enable write not applied.");
    a_record_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_FAULT_REC) |=>
        faultRecordEnable == $past(req.data))
        else $error("Record enable write not applied.");

    a_ctrl_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_AMP_CTRL) |=>
        reverseInputs == $past(req.data[REVERSE_BIT]) &&
        floatCurrentHigh == $past(req.data[FLOAT_CUR_BIT]))
        else $error("Control write not applied.");
    a_ctrl_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_AMP_CTRL) |=>
        rsp.data == 32'({$past(floatCurrentHigh), $past(reverseInputs)}))
        else $error("Control read wrong.");
    a_ctrl_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(wrStrobe && req.addr == ADDR_AMP_CTRL) |=>
        $stable(floatCurrentHigh) && $stable(reverseInputs))
        else $error("Control bits changed without a write.");

    a_ofs_first: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_OFS_FIRST) |=>
        secondOffsetDacCode == $past(req.data[14:8]))
        else $error("First offset codes misplaced.");
    a_ofs_first_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_OFS_FIRST) |=>
        firstOffsetDacCode == $past(req.data[DAC_W-1:0]))
        else $error("First offset low code misplaced.");
    a_ofs_gap_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_OFS_FIRST) |=>
        !rsp.data[DAC_W])
        else $error("Unused offset bit read back set.");
    a_ofs_second: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_OFS_SECOND) |=>
        positiveOffsetDacCode == $past(req.data[14:8]) &&
        thirdOffsetDacCode == $past(req.data[6:0]))
        else $error("Second offset codes misplaced.");
    a_ofs_third_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_OFS_THIRD) |=>
        stageThreeDacCode == $past(req.data[DAC_W-1:0]))
        else $error("Third offset write not applied.");
    a_ofs_third_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_OFS_THIRD) |=>
        rsp.data == 32'($past(stageThreeDacCode)))
        else $error("Third offset read wrong.");

    a_sensor_gain: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_EXT_GAIN) |=>
        sensorFirstGain == $past(req.data[SENS_FIRST_LSB +: FIRST_GAIN_W]) &&
        sensorSecondGain == $past(req.data[SENS_SECOND_LSB +: SECOND_GAIN_W]))
        else $error("Sensor path gain codes misplaced.");
    a_reference_gain: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_EXT_GAIN) |=>
        referenceFirstGain ==
        $past(req.data[REF_FIRST_LSB +: FIRST_GAIN_W]) &&
        referenceSecondGain ==
        $past(req.data[REF_SECOND_LSB +: SECOND_GAIN_W]))
        else $error("Reference path gain codes misplaced.");
    a_sink_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrStrobe && req.addr == ADDR_EXT_SINK) |=>
        extTempSinkCurrent == $past(req.data[2:0]))
        else $error("Sink current write not applied.");

    a_status_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && !req.write && req.addr == ADDR_NVM_STATUS) |=>
        rsp.data == {24'h000000, $past(nvmStatus)})
        else $error("Status byte read wrong.");
    a_busy_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.busy == $past(nvmState.busy))
        else $error("Busy bit read wrong.");
    a_done_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.progDone == $past(nvmState.progDone))
        else $error("Programming done bit read wrong.");
    a_ecc_used_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.eccUsed == $past(nvmState.eccUsed))
        else $error("Correction used bit read wrong.");
    a_ecc_fail_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.eccFail == $past(nvmState.eccFail))
        else $error("Correction failed bit read wrong.");
    a_read_timeout: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.readTimeout == $past(nvmState.readTimeout))
        else $error("Read timeout bit read wrong.");
    a_prog_timeout: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.progTimeout == $past(nvmState.progTimeout))
        else $error("Programming timeout bit read wrong.");
    a_enable_timeout: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && req.addr == ADDR_NVM_STATUS) |=>
        statusSeen.enableTimeout == $past(nvmState.enableTimeout))
        else $error("Enable step timeout bit read wrong.");

    a_rev_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && !req.write && req.addr == ADDR_SI_REV) |=>
        rsp.data == {16'h0000, SILICON_REV})
        else $error("Revision read wrong.");
    a_width_refused: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.wide != isWide(req.addr)) |=>
        !rsp.ok)
        else $error("Wrong command width accepted.");
    a_ro_ignored: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.write && !writeHit) |=>
        $stable(faultDetectEnable))
        else $error("Write to read-only changed state.");
    a_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdStrobe && !readHit) |=>
        rsp.data == RESET_ZERO && !rsp.ok)
        else $error("Unmapped read returned data.");

endmodule // csrb_bank
`default_nettype wire

// file: tb/csrb_master.sv
/*
 Master model issuing single register requests to the bank.
 Assumes requests are launched 1 ns after a rising edge of sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module csrb_master (
    input wire logic sys_clk,
    output csrb_pkg::csrb_req_type req,
    input wire csrb_pkg::csrb_rsp_type rsp
);
    import csrb_pkg::*;
    initial req = '0;
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic bad, output logic ok,
        output logic [31:0] q, output logic got);
        logic wide;
        @(posedge sys_clk);
        #1;
        wide = (a >= ADDR_FAULT_FLAGS && a <= ADDR_FAULT_REC);
        req.valid = 1'b1;
        req.write = wr;
        req.addr = a;
        req.wide = wide ^ bad;
        req.data = d;
        if (a == ADDR_OFS_FIRST)
            req.data[7] = 1'b0;
        @(posedge sys_clk);
        #1;
        req.valid = 1'b0;
        req.addr = ~a;
        req.data = ~d;
        got = rsp.valid;
        ok = rsp.ok;
        q = rsp.data;
    endtask
endmodule // csrb_master
`default_nettype wire

// file: tb/testbench.sv
/*
 Self-checking bench for the system register bank.
 Assumes the master model and a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import csrb_pkg::*;
    // Arbitrary revision value.
    localparam logic [15:0] REV = 16'h5A3C;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] faultEvent = '0;
    logic [31:0] faultClear = '0;
    csrb_nvm_type nvmState = '0;
    csrb_req_type req;
    csrb_rsp_type rsp;
    wire logic [54:0] codes;
    logic [31:0] detEn;
    logic [31:0] recEn;
    logic [31:0] mreg [256];
    logic [31:0] mflags;
    logic [7:0] rwAddr [9] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5,
        8'hB6, 8'hBD, 8'hBE};
    logic [7:0] roAddr [4] = '{8'hBB, 8'hBC, 8'hD0, 8'hB7};
    logic [7:0] a;
    logic ok;
    logic got;
    logic [31:0] q;
    int fails = 0;
    int comparisons = 0;
    integer seed = 32'hD4ED;
    always #5 sys_clk = ~sys_clk;
    csrb_bank #(.SILICON_REV(REV)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .req(req), .rsp(rsp), .faultEvent(faultEvent),
        .faultClear(faultClear), .nvmState(nvmState),
        .floatCurrentHigh(codes[54]), .reverseInputs(codes[53]),
        .ampGain(codes[52:48]), .secondOffsetDacCode(codes[47:41]),
        .firstOffsetDacCode(codes[40:34]),
        .positiveOffsetDacCode(codes[33:27]),
        .thirdOffsetDacCode(codes[26:20]), .stageThreeDacCode(codes[19:13]),
        .sensorFirstGain(codes[12:10]), .sensorSecondGain(codes[9:8]),
        .referenceFirstGain(codes[7:5]), .referenceSecondGain(codes[4:3]),
        .extTempSinkCurrent(codes[2:0]), .faultDetectEnable(detEn),
        .faultRecordEnable(recEn));
    csrb_master u_master (.sys_clk(sys_clk), .req(req), .rsp(rsp));
    function automatic logic [31:0] rw_mask(input logic [7:0] x);
        case (x)
            8'hB0: return 32'h0000_0003;
            8'hB1: return 32'h0000_001F;
            8'hB2, 8'hB3: return 32'h0000_7F7F;
            8'hB4: return 32'h0000_007F;
            8'hB5: return 32'h0000_03FF;
            8'hB6: return 32'h0000_0007;
            8'hBD, 8'hBE: return 32'hFFFF_FFFF;
            default: return 32'h0000_0000;
        endcase
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic outs();
        check(codes, {mreg[8'hB0][1:0], mreg[8'hB1][4:0], mreg[8'hB2][14:8],
            mreg[8'hB2][6:0], mreg[8'hB3][14:8], mreg[8'hB3][6:0],
            mreg[8'hB4][6:0], mreg[8'hB5][9:0], mreg[8'hB6][2:0]});
        check({detEn, recEn}, {mreg[8'hBD], mreg[8'hBE]});
    endtask
    task automatic rd(input logic [7:0] x, input logic bad,
        input logic [31:0] exp, input logic eok);
        u_master.xfer(1'b0, x, 32'h0000_0000, bad, ok, q, got);
        check({got, ok}, {1'b1, eok});
        if (eok)
            check(q, exp);
    endtask
    task automatic wr(input logic [7:0] x, input logic [31:0] v,
        input logic bad, input logic eok);
        if (x == ADDR_OFS_FIRST)
            v[7] = 1'b0;
        u_master.xfer(1'b1, x, v, bad, ok, q, got);
        check({got, ok, q}, {1'b1, eok, 32'h0000_0000});
        if (eok)
            mreg[x] = v & rw_mask(x);
        outs();
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        foreach (mreg[i]) mreg[i] = '0;
        mflags = '0;
    endtask
    task automatic give_verdict();
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end
    initial
    begin
        do_reset();
        outs();
        foreach (rwAddr[i]) rd(rwAddr[i], 1'b0, 32'h0, 1'b1);
        repeat (40)
        begin
            a = rwAddr[{$random(seed)} % 9];
            wr(a, $random(seed), 1'b0, 1'b1);
            rd(a, 1'b0, mreg[a], 1'b1);
        end
        foreach (roAddr[i]) wr(roAddr[i], '1, 1'b0, 1'b0);
        wr(ADDR_AMP_CTRL, ~mreg[8'hB0], 1'b1, 1'b0);
        rd(ADDR_FAULT_EN, 1'b1, 32'h0, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            nvmState = (i < 8) ? 8'h01 << i : 8'($random(seed));
            rd(ADDR_NVM_STATUS, 1'b0, {24'h0, nvmState}, 1'b1);
        end
        rd(ADDR_SI_REV, 1'b0, {16'h0000, REV}, 1'b1);
        repeat (4)
        begin
            wr(ADDR_FAULT_EN, $random(seed), 1'b0, 1'b1);
            faultEvent = $random(seed);
            mflags = mflags | (faultEvent & mreg[8'hBD]);
            @(posedge sys_clk);
            #1;
            faultEvent = '0;
            rd(ADDR_FAULT_FLAGS, 1'b0, mflags, 1'b1);
        end
        faultEvent = $random(seed);
        faultClear = '1;
        mflags = faultEvent & mreg[8'hBD];
        @(posedge sys_clk);
        #1;
        faultEvent = '0;
        faultClear = '0;
        rd(ADDR_FAULT_FLAGS, 1'b0, mflags, 1'b1);
        faultClear = '1;
        @(posedge sys_clk);
        #1;
        faultClear = '0;
        rd(ADDR_FAULT_FLAGS, 1'b0, 32'h0, 1'b1);
        do_reset();
        outs();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
